// ===== hdl/ccm_core.sv
// Purpose : phase generator, fetch/execute pipeline, program and data map
// Assumes : execution unit outside issues jumps, interrupts and data accesses
// Notes   : peripheral registers are left to other blocks; their offsets read zero here
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps

module ccm_core
    import ccm_pkg::*;
(
    input  wire logic                 clock_in,
    input  wire logic                 rst_in,
    input  wire ccm_flow_s            flow_in,
    input  wire ccm_data_req_s        data_req_in,
    input  wire logic [INSN_W-1:0]    prog_word_in,
    input  wire logic [3:0]           reg_addr_in,
    input  wire logic [7:0]           reg_wdata_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    output logic [7:0]                reg_rdata_out,
    output logic [3:0]                phase_out,
    output logic [PM_ADDR_W-1:0]      prog_addr_out,
    output logic [PC_W-1:0]           pc_out,
    output logic [INSN_W-1:0]         insn_out,
    output logic                      insn_valid_out,
    output logic [DA_W-1:0]           data_addr_out,
    output logic [7:0]                data_rdata_out,
    output logic                      is_special_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        ccm_phase_e          phase;
        logic [PC_W-1:0]     pc;
        logic [INSN_W-1:0]   fetched;
        logic [INSN_W-1:0]   insn;
        logic                insn_valid;
        logic                flush;
        logic [7:0]          status;
        logic [7:0]          pointer;
        logic [7:0]          pc_latch;
        logic [7:0]          int_ctrl;
        logic [7:0]          rdata;
        logic [7:0]          reg_rdata;
    } ccm_state_s;

    ccm_state_s state_q;
    ccm_state_s state_d;
    logic [7:0] gpr_mem [GPR_DEPTH];
    logic [DA_W-1:0] eff_addr;
    logic [6:0]      eff_off;
    logic            gpr_wr;

    // bank and offset to physical storage; common tops fold onto bank 0
    function automatic logic [DA_W-1:0] map_addr(input logic [1:0] bank,
                                                 input logic [6:0] off);
        if (off >= OFF_COMMON) begin
            map_addr = {2'b00, off};
        end else begin
            map_addr = {bank, off};
        end
    endfunction

    // only the five core registers live here; other low offsets are peripheral
    function automatic logic is_core(input logic [6:0] off);
        is_core = (off == OFF_PC_LOW) || (off == OFF_STATUS) ||
                  (off == OFF_POINTER) || (off == OFF_PC_LATCH) || (off == OFF_INT_CTRL);
    endfunction

    // ------------------------------------------------------------
    // data address decode
    // ------------------------------------------------------------
    // indirect uses the pointer plus the upper bank bit of status
    always_comb begin
        if (data_req_in.indirect || data_req_in.offset == OFF_INDIRECT) begin
            eff_off  = state_q.pointer[6:0];
            eff_addr = map_addr({state_q.status[STATUS_IRP], state_q.pointer[7]},
                                state_q.pointer[6:0]);
        end else begin
            eff_off  = data_req_in.offset;
            eff_addr = map_addr({state_q.status[STATUS_RP_HI], state_q.status[STATUS_RP_LO]},
                                data_req_in.offset);
        end
    end

    // gpr area starts above the special registers in every bank
    assign gpr_wr = data_req_in.wr && (state_q.phase == CCM_PH_FOUR) &&
                    (eff_off >= OFF_GPR_START);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        // one-hot rotation of the four phases
        case (state_q.phase)
            CCM_PH_ONE:   state_d.phase = CCM_PH_TWO;
            CCM_PH_TWO:   state_d.phase = CCM_PH_THREE;
            CCM_PH_THREE: state_d.phase = CCM_PH_FOUR;
            CCM_PH_FOUR:  state_d.phase = CCM_PH_ONE;
            default:      state_d.phase = CCM_PH_ONE;
        endcase

        // fetch side
        if (state_q.phase == CCM_PH_ONE) begin
            state_d.pc = PC_W'(state_q.pc + 1'b1);
            state_d.insn       = state_q.fetched;
            state_d.insn_valid = !state_q.flush;
            state_d.flush      = 1'b0;
        end
        if (state_q.phase == CCM_PH_FOUR) begin
            state_d.fetched = prog_word_in;
            // redirect lands on the next phase one fetch; word in flight is dropped
            if (flow_in.irq) begin
                state_d.pc    = IRQ_VECTOR;
                state_d.flush = 1'b1;
            end else if (flow_in.jump) begin
                state_d.pc    = flow_in.target;
                state_d.flush = 1'b1;
            end
        end

        // operand read in phase two
        if (state_q.phase == CCM_PH_TWO && data_req_in.rd) begin
            if (eff_off >= OFF_GPR_START) begin
                state_d.rdata = gpr_mem[eff_addr];
            end else begin
                case (eff_off)
                    OFF_PC_LOW:   state_d.rdata = state_q.pc[7:0];
                    OFF_STATUS:   state_d.rdata = state_q.status;
                    OFF_POINTER:  state_d.rdata = state_q.pointer;
                    OFF_PC_LATCH: state_d.rdata = state_q.pc_latch;
                    OFF_INT_CTRL: state_d.rdata = state_q.int_ctrl;
                    default:      state_d.rdata = ZERO_BYTE;
                endcase
            end
        end

        // destination write in phase four to core registers in any bank
        if (state_q.phase == CCM_PH_FOUR && data_req_in.wr && is_core(eff_off)) begin
            case (eff_off)
                OFF_STATUS:   state_d.status   = data_req_in.wdata;
                OFF_POINTER:  state_d.pointer  = data_req_in.wdata;
                OFF_PC_LATCH: state_d.pc_latch = data_req_in.wdata;
                OFF_INT_CTRL: state_d.int_ctrl = data_req_in.wdata;
                default:      ;
            endcase
        end

        // software port, same storage as the core offsets
        if (reg_wr_in) begin
            case ({3'b000, reg_addr_in})
                OFF_STATUS:   state_d.status   = reg_wdata_in;
                OFF_POINTER:  state_d.pointer  = reg_wdata_in;
                OFF_PC_LATCH: state_d.pc_latch = reg_wdata_in;
                OFF_INT_CTRL: state_d.int_ctrl = reg_wdata_in;
                default:      ;
            endcase
        end
        state_d.reg_rdata = ZERO_BYTE;
        if (reg_rd_in) begin
            case ({3'b000, reg_addr_in})
                OFF_PC_LOW:   state_d.reg_rdata = state_q.pc[7:0];
                OFF_STATUS:   state_d.reg_rdata = state_q.status;
                OFF_POINTER:  state_d.reg_rdata = state_q.pointer;
                OFF_PC_LATCH: state_d.reg_rdata = state_q.pc_latch;
                OFF_INT_CTRL: state_d.reg_rdata = state_q.int_ctrl;
                default:      state_d.reg_rdata = ZERO_BYTE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_q            <= '0;
            state_q.phase      <= CCM_PH_ONE;
            state_q.pc         <= RESET_VECTOR;
            state_q.status     <= STATUS_RESET;
            state_q.flush      <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // ram has no reset, so it lives beside the state struct
    always_ff @(posedge clock_in) begin
        if (gpr_wr) begin
            gpr_mem[eff_addr] <= data_req_in.wdata;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign phase_out      = state_q.phase;
    assign pc_out         = state_q.pc;
    assign prog_addr_out  = state_q.pc[PM_ADDR_W-1:0];
    assign insn_out       = state_q.insn;
    assign insn_valid_out = state_q.insn_valid;
    assign data_addr_out  = eff_addr;
    assign data_rdata_out = state_q.rdata;
    assign is_special_out = eff_off < OFF_GPR_START;
    assign reg_rdata_out  = state_q.reg_rdata;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_PHASE_ROTATE: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase == CCM_PH_ONE |=> state_q.phase == CCM_PH_TWO ##1
        state_q.phase == CCM_PH_THREE ##1 state_q.phase == CCM_PH_FOUR ##1 state_q.phase == CCM_PH_ONE)
        else $error("phase sequence broken");
    AST_PC_STEP: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase == CCM_PH_ONE |=> state_q.pc == PC_W'($past(state_q.pc) + 1'b1))
        else $error("pc did not step in phase one");
    AST_FETCH_CAPTURE: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase == CCM_PH_FOUR |=> state_q.fetched == $past(prog_word_in))
        else $error("fetched word not captured in phase four");
    AST_INSN_PRESENT: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase == CCM_PH_FOUR |-> ##1 (1'b1) ##1 state_q.insn == $past(state_q.fetched))
        else $error("instruction not presented in phase one");
    AST_WRAP: assert property (@(posedge clock_in) disable iff (rst_in)
        prog_addr_out == state_q.pc[11:0])
        else $error("program address not wrapped");
    AST_IRQ_VECTOR: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase == CCM_PH_FOUR && flow_in.irq |=> state_q.pc == IRQ_VECTOR)
        else $error("interrupt did not load vector");
    AST_FLUSH: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase == CCM_PH_FOUR && flow_in.jump |-> ##2 !state_q.insn_valid)
        else $error("prefetched word not discarded");
    AST_COMMON: assert property (@(posedge clock_in) disable iff (rst_in)
        !data_req_in.indirect && data_req_in.offset >= OFF_COMMON && data_req_in.offset != OFF_INDIRECT
        |-> data_addr_out[8:7] == 2'b00)
        else $error("common location not folded to bank zero");
    AST_BANK: assert property (@(posedge clock_in) disable iff (rst_in)
        !data_req_in.indirect && data_req_in.offset < OFF_COMMON && data_req_in.offset != OFF_INDIRECT
        |-> data_addr_out[8:7] == state_q.status[6:5])
        else $error("bank select not applied");

    // ------------------------------------------------------------
    // pipeline checks
    // ------------------------------------------------------------
    // phase register never leaves the four one-hot codes
    AST_PHASE_ONEHOT: assert property (@(posedge clock_in) disable iff (rst_in)
        $onehot(state_q.phase))
        else $error("phase code not one-hot");

    // counter only moves at phase one or on a taken redirect
    AST_PC_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase != CCM_PH_ONE &&
        !(state_q.phase == CCM_PH_FOUR && (flow_in.irq || flow_in.jump))
        |=> $stable(state_q.pc))
        else $error("pc moved outside phase one");

    // the full 13-bit counter rolls over, it is not cut to 4K
    AST_PC_ROLL: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase == CCM_PH_ONE && (&state_q.pc)
        |=> state_q.pc == '0)
        else $error("pc did not roll over at the top");

    // holding register only loads in phase four
    AST_FETCH_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase != CCM_PH_FOUR |=> $stable(state_q.fetched))
        else $error("fetched word changed outside phase four");

    // executing instruction stands for the whole cycle
    AST_INSN_HOLD: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase != CCM_PH_ONE
        |=> $stable(state_q.insn) && $stable(state_q.insn_valid))
        else $error("instruction changed mid cycle");

    // without a pending discard the next slot executes
    AST_VALID_RESUME: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase == CCM_PH_ONE && !state_q.flush |=> state_q.insn_valid)
        else $error("sequential instruction not issued");

    // a discard only ever covers one slot
    AST_FLUSH_CLEAR: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase == CCM_PH_ONE |=> !state_q.flush)
        else $error("discard lasted past one slot");

    // a jump loads its target in full
    AST_JUMP_TARGET: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase == CCM_PH_FOUR && flow_in.jump && !flow_in.irq
        |=> state_q.pc == $past(flow_in.target))
        else $error("jump target not loaded");

    // an interrupt also throws away the word beside it
    AST_IRQ_FLUSH: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase == CCM_PH_FOUR && flow_in.irq |=> state_q.flush)
        else $error("interrupt did not discard prefetch");

    // first cycle after reset starts at the reset vector, slot empty
    AST_RESET_START: assert property (@(posedge clock_in) disable iff (rst_in)
        $fell(rst_in)
        |-> state_q.pc == RESET_VECTOR && state_q.phase == CCM_PH_ONE && !state_q.insn_valid)
        else $error("reset did not start at the vector");

    // ------------------------------------------------------------
    // data side checks
    // ------------------------------------------------------------
    // operand register only loads in phase two
    AST_READ_PHASE: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase != CCM_PH_TWO |=> $stable(state_q.rdata))
        else $error("operand changed outside phase two");

    // a ram write lands at the decoded address
    AST_RAM_WRITE: assert property (@(posedge clock_in) disable iff (rst_in)
        gpr_wr |=> gpr_mem[$past(eff_addr)] == $past(data_req_in.wdata))
        else $error("ram write lost");

    // indirect access takes its offset from the pointer
    AST_INDIRECT_LOW: assert property (@(posedge clock_in) disable iff (rst_in)
        data_req_in.indirect || data_req_in.offset == OFF_INDIRECT
        |-> data_addr_out[6:0] == state_q.pointer[6:0])
        else $error("indirect offset not from pointer");

    // indirect bank comes from the pointer top bit and status
    AST_INDIRECT_BANK: assert property (@(posedge clock_in) disable iff (rst_in)
        (data_req_in.indirect || data_req_in.offset == OFF_INDIRECT) &&
        state_q.pointer[6:0] < OFF_COMMON
        |-> data_addr_out[8:7] == {state_q.status[STATUS_IRP], state_q.pointer[7]})
        else $error("indirect bank wrong");

    // common storage is shared by indirect access too
    AST_INDIRECT_COMMON: assert property (@(posedge clock_in) disable iff (rst_in)
        (data_req_in.indirect || data_req_in.offset == OFF_INDIRECT) &&
        state_q.pointer[6:0] >= OFF_COMMON
        |-> data_addr_out[8:7] == 2'b00)
        else $error("indirect common not folded");

    // direct access keeps the instruction's offset
    AST_DIRECT_LOW: assert property (@(posedge clock_in) disable iff (rst_in)
        !data_req_in.indirect && data_req_in.offset != OFF_INDIRECT
        |-> data_addr_out[6:0] == data_req_in.offset)
        else $error("direct offset altered");

    // upper offsets are ram in every bank
    AST_GPR_AREA: assert property (@(posedge clock_in) disable iff (rst_in)
        !data_req_in.indirect && data_req_in.offset >= OFF_GPR_START
        |-> !is_special_out)
        else $error("ram offset flagged special");

    // lower offsets are special registers in every bank
    AST_SFR_AREA: assert property (@(posedge clock_in) disable iff (rst_in)
        !data_req_in.indirect && data_req_in.offset != OFF_INDIRECT &&
        data_req_in.offset < OFF_GPR_START
        |-> is_special_out)
        else $error("special offset flagged ram");

    // ------------------------------------------------------------
    // register port checks
    // ------------------------------------------------------------
    // software write to status steers the bank select
    AST_STATUS_WRITE: assert property (@(posedge clock_in) disable iff (rst_in)
        reg_wr_in && {3'b000, reg_addr_in} == OFF_STATUS
        |=> state_q.status == $past(reg_wdata_in))
        else $error("status write lost");

    // software write to the pointer
    AST_POINTER_WRITE: assert property (@(posedge clock_in) disable iff (rst_in)
        reg_wr_in && {3'b000, reg_addr_in} == OFF_POINTER
        |=> state_q.pointer == $past(reg_wdata_in))
        else $error("pointer write lost");

    // read data come the cycle after the strobe
    AST_READ_PORT: assert property (@(posedge clock_in) disable iff (rst_in)
        reg_rd_in && {3'b000, reg_addr_in} == OFF_POINTER
        |=> reg_rdata_out == $past(state_q.pointer))
        else $error("pointer read wrong");

    // read data stand one cycle only
    AST_READ_IDLE: assert property (@(posedge clock_in) disable iff (rst_in)
        !reg_rd_in |=> reg_rdata_out == ZERO_BYTE)
        else $error("read data stood too long");

    // status is reachable through the data path in any bank
    AST_CORE_READ: assert property (@(posedge clock_in) disable iff (rst_in)
        state_q.phase == CCM_PH_TWO && data_req_in.rd && eff_off == OFF_STATUS
        |=> state_q.rdata == $past(state_q.status))
        else $error("status not mirrored on data read");

endmodule

// ===== hdl/ccm_pkg.sv
// Purpose : shared constants and carriers for the core cycle and memory map block
// Assumes : one 10 MHz clock standing in for the oscillator input
// Notes   : data addresses are 9 bits (bank select plus 7-bit offset)
package ccm_pkg;

    // ------------------------------------------------------------
    // phases and widths
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CCM_PH_ONE   = 4'b0001,
        CCM_PH_TWO   = 4'b0010,
        CCM_PH_THREE = 4'b0100,
        CCM_PH_FOUR  = 4'b1000
    } ccm_phase_e;

    localparam int PC_W      = 13;
    localparam int PM_ADDR_W = 12;
    localparam int INSN_W    = 14;
    localparam int DA_W      = 9;
    localparam int GPR_DEPTH = 512;

    localparam logic [PC_W-1:0] RESET_VECTOR = 13'h0000;
    localparam logic [PC_W-1:0] IRQ_VECTOR   = 13'h0004;

    // ------------------------------------------------------------
    // register offsets and fields
    // ------------------------------------------------------------
    localparam logic [6:0] OFF_INDIRECT   = 7'h00;
    localparam logic [6:0] OFF_PC_LOW     = 7'h02;
    localparam logic [6:0] OFF_STATUS     = 7'h03;
    localparam logic [6:0] OFF_POINTER    = 7'h04;
    localparam logic [6:0] OFF_PC_LATCH   = 7'h0A;
    localparam logic [6:0] OFF_INT_CTRL   = 7'h0B;
    localparam logic [6:0] OFF_GPR_START  = 7'h20;
    localparam logic [6:0] OFF_COMMON     = 7'h70;
    localparam int         STATUS_RP_LO   = 5;
    localparam int         STATUS_RP_HI   = 6;
    localparam int         STATUS_IRP     = 7;
    localparam logic [7:0] STATUS_RESET   = 8'h18;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic            jump;
        logic [PC_W-1:0] target;
        logic            irq;
    } ccm_flow_s;

    typedef struct packed {
        logic            rd;
        logic            wr;
        logic            indirect;
        logic [6:0]      offset;
        logic [7:0]      wdata;
    } ccm_data_req_s;

endpackage

// ===== testbench/ccm_core_tb.sv
// Purpose : self-checking bench for the core cycle and memory map block
// Assumes : the bench counts phases itself, starting at the release of reset
// Notes   : drivers queue expected results; the negedge monitor pops and compares
`timescale 1ns/1ps
module ccm_core_tb import ccm_pkg::*;;

    logic                 clock_in;
    logic                 rst_in;
    ccm_flow_s            flow_in;
    ccm_data_req_s        data_req_in;
    logic [INSN_W-1:0]    prog_word_in;
    logic [3:0]           reg_addr_in;
    logic [7:0]           reg_wdata_in;
    logic                 reg_wr_in;
    logic                 reg_rd_in;
    logic [7:0]           reg_rdata_out;
    logic [3:0]           phase_out;
    logic [PM_ADDR_W-1:0] prog_addr_out;
    logic [PC_W-1:0]      pc_out;
    logic [INSN_W-1:0]    insn_out;
    logic                 insn_valid_out;
    logic [DA_W-1:0]      data_addr_out;
    logic [7:0]           data_rdata_out;
    logic                 is_special_out;
    int                   err_total;
    int                   checks_done;
    int                   cyc;
    int                   seed;
    logic                 run;
    logic                 hold;
    logic                 rd_seen;
    logic [7:0]           st_m;
    logic [7:0]           ptr_m;
    logic [7:0]           v;
    logic [6:0]           eo;
    logic [1:0]           eb;
    logic [INSN_W:0]      ie;
    logic [PC_W-1:0]      pc_m;
    ccm_flow_s            cur_flow;
    ccm_data_req_s        cur_req;
    logic [7:0]           rd_q[$];
    logic [7:0]           dat_q[$];
    logic [PC_W-1:0]      pc_q[$];
    logic [INSN_W:0]      ins_q[$];

    ccm_core DUT (.clock_in(clock_in), .rst_in(rst_in), .flow_in(flow_in), .data_req_in(data_req_in),
        .prog_word_in(prog_word_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .phase_out(phase_out),
        .prog_addr_out(prog_addr_out), .pc_out(pc_out), .insn_out(insn_out), .insn_valid_out(insn_valid_out),
        .data_addr_out(data_addr_out), .data_rdata_out(data_rdata_out), .is_special_out(is_special_out));

    // 10 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #50 clock_in = ~clock_in;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // one clock: register port, flow, data request and, in phase four, a fresh program word
    task automatic tick(input logic wr, input logic rd, input logic [3:0] a, input logic [7:0] d);
        logic [INSN_W-1:0] w;
        @(posedge clock_in);
        cyc++;
        if (!hold) begin
            cur_req = '0;
            cur_req.offset = 7'($random(seed));
            cur_req.indirect = 1'($random(seed));
        end
        reg_wr_in <= wr;
        reg_rd_in <= rd;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        flow_in <= cur_flow;
        data_req_in <= cur_req;
        if (cyc % 4 == 3) begin
            w = INSN_W'($random(seed));
            prog_word_in <= w;
            // a taken jump or interrupt throws away the word fetched beside it
            ins_q.push_back({!(cur_flow.jump | cur_flow.irq), w});
            pc_m = cur_flow.irq ? IRQ_VECTOR : (cur_flow.jump ? cur_flow.target : pc_m + 1'b1);
            pc_q.push_back(pc_m);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        tick(1'b1, 1'b0, a, d);
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        tick(1'b0, 1'b1, a, 8'h00);
    endtask

    // one whole instruction cycle, aligned so that its first clock is phase one
    task automatic instr(input logic j, input logic i, input logic [PC_W-1:0] t, input logic rd,
                         input logic wr, input logic [6:0] o, input logic [7:0] x);
        while (cyc % 4 != 3) tick(1'b0, 1'b0, 4'h0, 8'h00);
        hold = 1'b1;
        cur_flow = '{jump: j, target: t, irq: i};
        cur_req = '{rd: rd, wr: wr, indirect: 1'b0, offset: o, wdata: x};
        if (rd) dat_q.push_back(x);
        repeat (4) tick(1'b0, 1'b0, 4'h0, 8'h00);
        hold = 1'b0;
        cur_flow = '0;
    endtask

    // ------------------------------------------------------------
    // monitor: bench copy of status and pointer, then the comparisons
    // ------------------------------------------------------------
    always @(posedge clock_in) begin
        rd_seen <= reg_rd_in;
        if (rst_in) begin
            st_m <= STATUS_RESET;
            ptr_m <= ZERO_BYTE;
        end else if (reg_wr_in && reg_addr_in == 4'h3) begin
            st_m <= reg_wdata_in;
        end else if (reg_wr_in && reg_addr_in == 4'h4) begin
            ptr_m <= reg_wdata_in;
        end
    end

    // sampled mid-cycle so every registered output has settled
    always @(negedge clock_in) begin
        if (run) begin
            chk(phase_out, 4'b0001 << (cyc % 4));
            chk(prog_addr_out, pc_out[PM_ADDR_W-1:0]);
            eo = (data_req_in.indirect || data_req_in.offset == OFF_INDIRECT) ? ptr_m[6:0] : data_req_in.offset;
            eb = (data_req_in.indirect || data_req_in.offset == OFF_INDIRECT) ? {st_m[7], ptr_m[7]} : st_m[6:5];
            chk(data_addr_out, (eo >= OFF_COMMON) ? {2'b00, eo} : {eb, eo});
            chk(is_special_out, eo < OFF_GPR_START);
            // read data stand only in the cycle after the strobe
            if (rd_seen) begin
                chk(reg_rdata_out, rd_q.pop_front());
            end else begin
                chk(reg_rdata_out, 8'h00);
            end
            if (cyc % 4 == 0) chk(pc_out, pc_q.pop_front());
            if (cyc % 4 == 2) begin
                ie = ins_q.pop_front();
                chk(insn_valid_out, ie[INSN_W]);
                if (ie[INSN_W]) chk(insn_out, ie[INSN_W-1:0]);
                if (data_req_in.rd) chk(data_rdata_out, dat_q.pop_front());
            end
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 56025;
        {err_total, checks_done, cyc} = '0;
        {run, hold, reg_wr_in, reg_rd_in} = '0;
        {flow_in, cur_flow, data_req_in, cur_req, prog_word_in, reg_addr_in, reg_wdata_in} = '0;
        pc_m = RESET_VECTOR;
        rst_in = 1'b1;
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        pc_q.push_back(RESET_VECTOR);
        ins_q.push_back('0);
        run = 1'b1;
        reg_read(4'h3, STATUS_RESET);
        reg_read(4'h4, ZERO_BYTE);
        reg_read(4'hA, ZERO_BYTE);
        reg_read(4'hB, ZERO_BYTE);
        reg_write(4'hE, 8'hFF);
        reg_read(4'hE, ZERO_BYTE);
        reg_read(4'h1, ZERO_BYTE);
        // back-to-back write then read of the pointer, pc latch and interrupt control registers
        repeat (4) begin
            for (int k = 0; k < 3; k++) begin
                v = 8'($random(seed));
                reg_write(k == 0 ? 4'h4 : (k == 1 ? 4'hA : 4'hB), v);
                reg_read(k == 0 ? 4'h4 : (k == 1 ? 4'hA : 4'hB), v);
            end
        end
        repeat (6) instr(1'b0, 1'b0, '0, 1'b0, 1'b0, 7'h00, 8'h00);
        // jump near the top of the counter so it rolls past 8K
        instr(1'b1, 1'b0, 13'h1FFE, 1'b0, 1'b0, 7'h00, 8'h00);
        repeat (4) instr(1'b0, 1'b0, '0, 1'b0, 1'b0, 7'h00, 8'h00);
        instr(1'b1, 1'b1, 13'h0123, 1'b0, 1'b0, 7'h00, 8'h00);
        instr(1'b0, 1'b0, '0, 1'b0, 1'b0, 7'h00, 8'h00);
        // common storage written in bank 2, read back from banks 0 and 1 and indirectly
        v = 8'($random(seed));
        reg_write(4'h3, 8'h58);
        instr(1'b0, 1'b0, '0, 1'b0, 1'b1, 7'h75, v);
        reg_write(4'h3, 8'h18);
        instr(1'b0, 1'b0, '0, 1'b1, 1'b0, 7'h75, v);
        reg_write(4'h3, 8'h38);
        instr(1'b0, 1'b0, '0, 1'b1, 1'b0, 7'h75, v);
        reg_write(4'h4, 8'hF5);
        instr(1'b0, 1'b0, '0, 1'b1, 1'b0, 7'h00, v);
        reg_write(4'h3, 8'h78);
        instr(1'b0, 1'b0, '0, 1'b1, 1'b0, OFF_STATUS, 8'h78);
        reg_read(4'h3, 8'h78);
        repeat (8) tick(1'b0, 1'b0, 4'h0, 8'h00);
        conclude();
    end

endmodule
